// ### osd_cmd_pkg.sv
// constants used by the display command interpreter
package osd_cmd_pkg;

	// ***********************************
	// single-byte command codes
	// ***********************************
	localparam logic [7:0] OP_IDLE        = 8'h00;
	localparam logic [7:0] OP_RETURN      = 8'h30;
	localparam logic [7:0] OP_ERASE_EOL   = 8'h31;
	localparam logic [7:0] OP_SCROLL_SET  = 8'h32;
	localparam logic [7:0] OP_POPON_SET   = 8'h33;
	localparam logic [7:0] OP_SWAP        = 8'h36;
	localparam logic [7:0] OP_ERASE_SHOWN = 8'h37;
	localparam logic [7:0] OP_ERASE_HIDE  = 8'h38;
	localparam logic [7:0] OP_READ_ONE    = 8'hf8;
	localparam logic [7:0] OP_READ_TWO    = 8'hf9;
	localparam logic [7:0] OP_RESET_1     = 8'hfb;
	localparam logic [7:0] OP_RESET_2     = 8'hfc;

	// ***********************************
	// two-byte command codes, plus the prefixes of the one-byte read commands
	// ***********************************
	localparam logic [7:0] OP_DISP_ROW    = 8'ha0;
	localparam logic [7:0] OP_PHYS_ROW    = 8'ha1;
	localparam logic [7:0] OP_CURSOR      = 8'ha2;
	localparam logic [7:0] OP_PUT_GLYPH   = 8'ha3;
	localparam logic [7:0] OP_ROW_MAP     = 8'ha4;
	localparam logic [7:0] OP_PUT_WIDE    = 8'ha5;
	localparam logic [7:0] OP_WAIT        = 8'ha6;
	localparam logic [7:0] OP_GRAPHICS    = 8'ha7;
	localparam logic [7:0] OP_EXTENDED    = 8'ha8;
	localparam logic [2:0] OP_WRITE_HI    = 3'b110;
	localparam logic [4:0] OP_RDS1_HI     = 5'b01000;
	localparam logic [4:0] OP_RDS2_HI     = 5'b01100;
	localparam logic [2:0] RDS2_LAST      = 3'h6;

	// ***********************************
	// argument fields
	// ***********************************
	localparam int ARG_SHOW   = 4;
	localparam int ARG_TALL   = 5;
	localparam logic [5:0] COL_FIRST = 6'h01;
	localparam logic [5:0] COL_LAST  = 6'h20;

	// ***********************************
	// register map
	// ***********************************
	localparam logic [4:0] VIDEO_SETUP_ADDR   = 5'h00;
	localparam logic [4:0] DISPLAY_STYLE_ADDR = 5'h01;
	localparam logic [7:0] VIDEO_SETUP_RST    = 8'h00;
	localparam logic [7:0] VIDEO_SETUP_MASK   = 8'h0f;
	localparam logic [7:0] DISPLAY_STYLE_RST  = 8'hc0;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;
	localparam logic [7:0] EMPTY_BUF_B        = 8'hff;
	localparam int VS_TV_STD   = 0;
	localparam int VS_GREY     = 1;
	localparam int VS_HREF     = 2;
	localparam int VS_VREF     = 3;
	localparam int DS_T_SHADOW = 0;
	localparam int DS_T_TALL   = 1;
	localparam int DS_T_ATTR   = 2;
	localparam int DS_C_SHADOW = 3;
	localparam int DS_C_TALL   = 4;
	localparam int DS_C_ATTR   = 5;
	localparam int DS_O_SHADOW = 6;
	localparam int DS_O_TALL   = 7;

	// ***********************************
	// status byte and row heights
	// ***********************************
	localparam int SB_LOCK = 0;
	localparam int SB_FLD  = 1;
	localparam int SB_OVWR = 2;
	localparam int SB_IRQ  = 3;
	localparam int SB_OVRN = 4;
	localparam int SB_TWO  = 5;
	localparam int SB_WAIT = 6;
	localparam int SB_RDY  = 7;
	localparam logic [3:0] LINES_TALL  = 4'd15;
	localparam logic [3:0] LINES_SHORT = 4'd13;

	typedef enum logic [1:0] {ST_IDLE, ST_ARG, ST_WAIT} exec_state_t;

endpackage : osd_cmd_pkg

// ### pin_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,   // device clock
	input  wire logic         rst,    // async reset
	input  wire logic [W-1:0] pin,    // asynchronous inputs
	output logic      [W-1:0] synced  // retimed copy
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta   <= '0;
			synced <= '0;
		end else begin
			meta   <= pin;
			synced <= meta;
		end
	end
endmodule : pin_sync

// ### frame_wait_timer.sv
// frame counter that suspends command execution
`timescale 1ns/1ps
module frame_wait_timer (
	input  wire logic       mclk,       // device clock
	input  wire logic       rst,        // async reset
	input  wire logic       start,      // load a new count
	input  wire logic [7:0] frames,     // frames to wait
	input  wire logic       frame_tick, // one pulse per frame
	output logic            busy        // wait in progress
);
	logic [7:0] remain;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			remain <= 8'h00;
			busy   <= 1'b0;
		end else if (start) begin
			remain <= frames;
			busy   <= (frames != 8'h00);
		end else if (busy && frame_tick) begin
			remain <= remain - 8'h01;
			busy   <= (remain != 8'h01);
		end
	end

	property p_wait_ends;
		@(posedge mclk) disable iff (rst)
		busy && frame_tick && remain == 8'h01 |=> !busy;
	endproperty
	a_wait_ends: assert property (p_wait_ends) else $error("wait did not end");
endmodule : frame_wait_timer

// ### line21_osd_command_and_setup_regs.sv
// command interpreter, status byte and setup registers for the display
`timescale 1ns/1ps
module line21_osd_command_and_setup_regs
	import osd_cmd_pkg::*;
(
	input  wire logic       mclk,              // device clock, 125 MHz
	input  wire logic       rst,               // async reset, active high
	input  wire logic [7:0] rx_byte,           // command byte from serial port
	input  wire logic       rx_valid,          // rx_byte strobe
	input  wire logic       stat_ack,          // host read the status byte
	input  wire logic       rd_ack_a,          // host read buffer a
	input  wire logic       rd_ack_b,          // host read buffer b
	input  wire logic       irq_any,           // non-data interrupt pending
	input  wire logic       lock_pin,          // sync lock, asynchronous
	input  wire logic       field_pin,         // field one, asynchronous
	input  wire logic       frame_pin,         // frame sync, asynchronous
	output logic      [7:0] port_status,       // serial status byte
	output logic      [7:0] out_buf_a,         // output buffer a
	output logic      [7:0] out_buf_b,         // output buffer b
	output logic      [7:0] video_setup,       // setup register
	output logic      [7:0] display_style,     // display style register
	output logic      [3:0] text_row_lines,    // scan lines per text row
	output logic      [3:0] caption_row_lines, // scan lines per caption row
	output logic      [3:0] overlay_row_lines, // scan lines per overlay row
	output logic            text_attr_on,      // text enhanced attributes
	output logic            caption_attr_on,   // caption enhanced attributes
	output logic            overlay_attr_on,   // overlay enhanced attributes
	output logic            irq_out_pin,       // shared pin output level
	output logic            irq_out_oe,        // shared pin output enable
	output logic            popon_style,       // 1 pop-on, 0 scrolling
	output logic            charset_ext,       // extended set for C0h-FFh
	output logic      [3:0] disp_row,          // current display row
	output logic            disp_tall,         // display row double height
	output logic      [3:0] phys_row,          // current physical row
	output logic      [5:0] cursor_col,        // cursor column
	output logic            glyph_we,          // glyph write pulse
	output logic      [3:0] glyph_row,         // glyph physical row
	output logic      [5:0] glyph_col,         // glyph column
	output logic      [7:0] glyph_code,        // glyph code
	output logic            glyph_wide,        // glyph double width
	output logic            map_we,            // row map write pulse
	output logic      [3:0] map_disp,          // mapped display row
	output logic            map_show,          // row shown
	output logic            map_tall,          // row double height
	output logic            carriage_return,   // return pulse
	output logic            erase_to_row_end,  // erase pulse
	output logic            swap_memories,     // swap pulse
	output logic            erase_shown_memory,  // erase shown pulse
	output logic            erase_hidden_memory  // erase hidden pulse
);
	// ***********************************
	// pin retiming
	// ***********************************
	logic [2:0] pins_s;
	logic       frame_d;
	logic       frame_tick;

	pin_sync #(.W(3)) u_sync (
		.mclk   (mclk),
		.rst    (rst),
		.pin    ({frame_pin, field_pin, lock_pin}),
		.synced (pins_s)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			frame_d <= 1'b0;
		end else begin
			frame_d <= pins_s[2];
		end
	end
	assign frame_tick = pins_s[2] && !frame_d;

	// ***********************************
	// input buffer and reset sequence
	// ***********************************
	exec_state_t state;
	logic [7:0]  in_byte;
	logic        in_full;
	logic [7:0]  op;
	logic [1:0]  seq_stage;
	logic        soft_rst;
	logic        tmr_busy;
	logic        fire;
	logic        busy;
	logic        free_code;
	logic        accept;
	logic        drop;

	assign fire      = in_full && state != ST_WAIT;
	assign busy      = in_full || state == ST_WAIT;
	assign free_code = rx_byte == OP_IDLE || rx_byte == OP_READ_ONE ||
			rx_byte == OP_READ_TWO || rx_byte == OP_RESET_1 || rx_byte == OP_RESET_2;
	assign accept    = rx_valid && !(busy && free_code) && (!in_full || fire);
	assign drop      = rx_valid && !(busy && free_code) && in_full && !fire;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			in_full <= 1'b0;
			in_byte <= 8'h00;
		end else if (accept) begin
			in_full <= 1'b1;
			in_byte <= rx_byte;
		end else if (fire) begin
			in_full <= 1'b0;
		end
	end

	// reset sequence is honoured even while waiting
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			seq_stage <= 2'd0;
			soft_rst  <= 1'b0;
		end else begin
			soft_rst <= rx_valid && seq_stage == 2'd2 && rx_byte == OP_IDLE;
			if (rx_valid) begin
				if (rx_byte == OP_RESET_1)
					seq_stage <= 2'd1;
				else if (rx_byte == OP_RESET_2 && seq_stage == 2'd1)
					seq_stage <= 2'd2;
				else
					seq_stage <= 2'd0;
			end
		end
	end

	// ***********************************
	// command sequencing
	// ***********************************
	logic exec1;
	logic exec2;
	logic tmr_start;

	assign exec1     = fire && state == ST_IDLE;
	assign exec2     = fire && state == ST_ARG;
	assign tmr_start = exec2 && op == OP_WAIT;

	frame_wait_timer u_wait (
		.mclk       (mclk),
		.rst        (rst),
		.start      (tmr_start),
		.frames     (in_byte),
		.frame_tick (frame_tick),
		.busy       (tmr_busy)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			op    <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (exec1 && (in_byte[7:4] == 4'ha || in_byte[7:5] == OP_WRITE_HI)) begin
						op    <= in_byte;
						state <= ST_ARG;
					end
				end
				ST_ARG: begin
					if (exec2)
						state <= (op == OP_WAIT) ? ST_WAIT : ST_IDLE;
				end
				ST_WAIT: begin
					if (!tmr_busy)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ***********************************
	// setup registers
	// ***********************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			video_setup   <= VIDEO_SETUP_RST;
			display_style <= DISPLAY_STYLE_RST;
		end else if (soft_rst) begin
			video_setup   <= VIDEO_SETUP_RST;
			display_style <= DISPLAY_STYLE_RST;
		end else if (exec2 && op[7:5] == OP_WRITE_HI) begin
			if (op[4:0] == VIDEO_SETUP_ADDR)
				video_setup <= in_byte & VIDEO_SETUP_MASK;
			else if (op[4:0] == DISPLAY_STYLE_ADDR)
				display_style <= in_byte;
		end
	end

	// derived display controls
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			text_row_lines    <= LINES_SHORT;
			caption_row_lines <= LINES_SHORT;
			overlay_row_lines <= LINES_TALL;
			text_attr_on      <= 1'b1;
			caption_attr_on   <= 1'b1;
			overlay_attr_on   <= 1'b1;
			irq_out_pin       <= 1'b0;
			irq_out_oe        <= 1'b1;
		end else begin
			text_row_lines <= (display_style[DS_T_TALL] || video_setup[VS_TV_STD]) ?
					LINES_TALL : LINES_SHORT;
			caption_row_lines <= (display_style[DS_C_TALL] || video_setup[VS_TV_STD]) ?
					LINES_TALL : LINES_SHORT;
			overlay_row_lines <= (display_style[DS_O_TALL] || video_setup[VS_TV_STD]) ?
					LINES_TALL : LINES_SHORT;
			text_attr_on    <= !display_style[DS_T_ATTR];
			caption_attr_on <= !display_style[DS_C_ATTR];
			overlay_attr_on <= 1'b1;
			irq_out_pin     <= irq_any && !video_setup[VS_VREF];
			irq_out_oe      <= !video_setup[VS_VREF];
		end
	end

	// ***********************************
	// read selects and status
	// ***********************************
	logic output_waiting;
	logic two_bytes_ready;
	logic output_overwritten;
	logic input_overrun;
	logic load_rd;

	function automatic logic [7:0] reg_read(input logic [2:0] a);
		if (a == VIDEO_SETUP_ADDR[2:0])
			reg_read = video_setup;
		else if (a == DISPLAY_STYLE_ADDR[2:0])
			reg_read = display_style;
		else
			reg_read = UNMAPPED_READ;
	endfunction : reg_read

	assign load_rd = exec1 && (in_byte[7:3] == OP_RDS1_HI ||
			(in_byte[7:3] == OP_RDS2_HI && in_byte[2:0] <= RDS2_LAST));

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_buf_a       <= 8'h00;
			out_buf_b       <= EMPTY_BUF_B;
			two_bytes_ready <= 1'b0;
		end else if (load_rd) begin
			out_buf_a <= reg_read(in_byte[2:0]);
			if (in_byte[5]) begin
				out_buf_b       <= reg_read(in_byte[2:0] + 3'h1);
				two_bytes_ready <= 1'b1;
			end else begin
				out_buf_b       <= EMPTY_BUF_B;
				two_bytes_ready <= 1'b0;
			end
		end
	end

	// set wins over clear for every sticky flag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			output_waiting     <= 1'b0;
			output_overwritten <= 1'b0;
			input_overrun      <= 1'b0;
		end else begin
			if (load_rd)
				output_waiting <= 1'b1;
			else if (two_bytes_ready ? rd_ack_b : rd_ack_a)
				output_waiting <= 1'b0;
			if (load_rd && output_waiting)
				output_overwritten <= 1'b1;
			else if (stat_ack)
				output_overwritten <= 1'b0;
			if (drop)
				input_overrun <= 1'b1;
			else if (stat_ack)
				input_overrun <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_status <= 8'h80;
		end else begin
			port_status[SB_LOCK] <= pins_s[0];
			port_status[SB_FLD]  <= pins_s[1];
			port_status[SB_OVWR] <= output_overwritten;
			port_status[SB_IRQ]  <= irq_any;
			port_status[SB_OVRN] <= input_overrun;
			port_status[SB_TWO]  <= two_bytes_ready;
			port_status[SB_WAIT] <= output_waiting;
			port_status[SB_RDY]  <= !in_full;
		end
	end

	// ***********************************
	// display command execution
	// ***********************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			carriage_return     <= 1'b0;
			erase_to_row_end    <= 1'b0;
			swap_memories       <= 1'b0;
			erase_shown_memory  <= 1'b0;
			erase_hidden_memory <= 1'b0;
			popon_style         <= 1'b0;
		end else begin
			carriage_return     <= exec1 && in_byte == OP_RETURN && !popon_style;
			erase_to_row_end    <= exec1 && in_byte == OP_ERASE_EOL;
			swap_memories       <= exec1 && in_byte == OP_SWAP;
			erase_shown_memory  <= exec1 && in_byte == OP_ERASE_SHOWN;
			erase_hidden_memory <= exec1 && in_byte == OP_ERASE_HIDE;
			if (soft_rst)
				popon_style <= 1'b0;
			else if (exec1 && in_byte == OP_SCROLL_SET)
				popon_style <= 1'b0;
			else if (exec1 && in_byte == OP_POPON_SET)
				popon_style <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			disp_row    <= 4'h0;
			disp_tall   <= 1'b0;
			phys_row    <= 4'h0;
			cursor_col  <= 6'h00;
			charset_ext <= 1'b0;
		end else if (soft_rst) begin
			disp_row    <= 4'h0;
			disp_tall   <= 1'b0;
			phys_row    <= 4'h0;
			cursor_col  <= 6'h00;
			charset_ext <= 1'b0;
		end else if (exec2) begin
			if (op == OP_DISP_ROW) begin
				disp_row   <= in_byte[3:0];
				disp_tall  <= in_byte[ARG_TALL];
				cursor_col <= COL_FIRST;
			end else if (op == OP_PHYS_ROW) begin
				phys_row <= in_byte[3:0];
			end else if (op == OP_CURSOR) begin
				cursor_col <= (in_byte > {2'b00, COL_LAST}) ? COL_LAST : in_byte[5:0];
			end else if (op == OP_PUT_GLYPH || op == OP_PUT_WIDE) begin
				if (cursor_col != COL_LAST)
					cursor_col <= cursor_col + 6'h01;
			end else if (op == OP_GRAPHICS) begin
				charset_ext <= 1'b0;
			end else if (op == OP_EXTENDED) begin
				charset_ext <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			glyph_we   <= 1'b0;
			glyph_row  <= 4'h0;
			glyph_col  <= 6'h00;
			glyph_code <= 8'h00;
			glyph_wide <= 1'b0;
			map_we     <= 1'b0;
			map_disp   <= 4'h0;
			map_show   <= 1'b0;
			map_tall   <= 1'b0;
		end else begin
			glyph_we <= exec2 && (op == OP_PUT_GLYPH || op == OP_PUT_WIDE);
			map_we   <= exec2 && op == OP_ROW_MAP;
			if (exec2) begin
				glyph_row  <= phys_row;
				glyph_col  <= cursor_col;
				glyph_code <= in_byte;
				glyph_wide <= op == OP_PUT_WIDE;
				map_disp   <= in_byte[3:0];
				map_show   <= in_byte[ARG_SHOW];
				map_tall   <= in_byte[ARG_TALL];
			end
		end
	end

	// ***********************************
	// checks
	// ***********************************
	sequence s_put_glyph;
		exec2 && op == OP_PUT_GLYPH && cursor_col != COL_LAST;
	endsequence
	property p_put_glyph;
		@(posedge mclk) disable iff (rst)
		s_put_glyph |=> glyph_we && glyph_code == $past(in_byte) &&
			cursor_col == $past(cursor_col) + 6'h01;
	endproperty
	a_put_glyph: assert property (p_put_glyph) else $error("glyph write wrong");

	property p_row_cursor;
		@(posedge mclk) disable iff (rst)
		exec2 && op == OP_DISP_ROW && !soft_rst |=> cursor_col == COL_FIRST;
	endproperty
	a_row_cursor: assert property (p_row_cursor) else $error("cursor not column one");

	// one frame or none may end the wait before the hold window
	sequence s_wait_start;
		exec2 && op == OP_WAIT && in_byte > 8'h01;
	endsequence
	property p_wait_holds;
		@(posedge mclk) disable iff (rst)
		s_wait_start |=> state == ST_WAIT ##1 (!fire throughout (state == ST_WAIT)[*2]);
	endproperty
	a_wait_holds: assert property (p_wait_holds) else $error("ran during wait");

	property p_overrun;
		@(posedge mclk) disable iff (rst)
		drop |=> input_overrun ##1 port_status[SB_OVRN];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_one_byte_read;
		@(posedge mclk) disable iff (rst)
		load_rd && !in_byte[5] |=> out_buf_b == EMPTY_BUF_B && !two_bytes_ready && output_waiting;
	endproperty
	a_one_byte_read: assert property (p_one_byte_read) else $error("buffer b not ones");

	property p_dav_clear;
		@(posedge mclk) disable iff (rst)
		output_waiting && !two_bytes_ready && rd_ack_a && !load_rd |=> ##1 !port_status[SB_WAIT];
	endproperty
	a_dav_clear: assert property (p_dav_clear) else $error("waiting flag stuck");

	property p_reserved_zero;
		@(posedge mclk) disable iff (rst)
		video_setup[7:4] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_overlay_lines;
		@(posedge mclk) disable iff (rst)
		display_style[DS_O_TALL] |=> overlay_row_lines == LINES_TALL;
	endproperty
	a_overlay_lines: assert property (p_overlay_lines) else $error("overlay rows short");

	property p_irq_pin;
		@(posedge mclk) disable iff (rst)
		$rose(video_setup[VS_VREF]) |=> !irq_out_oe && !irq_out_pin;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("pin still driven");

endmodule : line21_osd_command_and_setup_regs

// ### host_port_model.sv
// host side of the serial command port
`timescale 1ns/1ps
module host_port_model (
	input  wire logic       mclk,             // device clock
	input  wire logic [7:0] port_status,      // status byte
	output logic      [7:0] rx_byte = 8'h00,  // command byte
	output logic            rx_valid = 1'b0,  // byte strobe
	output logic            stat_ack = 1'b0,  // status read
	output logic            rd_ack_a = 1'b0,  // buffer a read
	output logic            rd_ack_b = 1'b0,  // buffer b read
	output logic            frame_pin = 1'b0  // frame sync
);
	// ***
	// host tasks
	// ***
	// set only to provoke an input overrun on purpose
	bit ignore_ready = 1'b0;
	task automatic send(input logic [7:0] b, output bit late);
		late = 1'b0;
		// only free codes skip the wait for ready, unless ignore_ready is set
		if (!ignore_ready && !(b inside {8'h00, 8'hf8, 8'hf9, 8'hfb, 8'hfc})) begin
			for (int i = 0; i < 300 && port_status[7] !== 1'b1; i++)
				@(negedge mclk);
			late = port_status[7] !== 1'b1;
		end
		rx_byte = b;
		rx_valid = 1'b1;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_byte = ~b;
		@(negedge mclk);
	endtask : send
	task automatic ack(input logic [2:0] m);
		{stat_ack, rd_ack_a, rd_ack_b} = m;
		@(negedge mclk);
		{stat_ack, rd_ack_a, rd_ack_b} = 3'b000;
	endtask : ack
	task automatic frame();
		frame_pin = 1'b1;
		repeat (4) @(negedge mclk);
		frame_pin = 1'b0;
		repeat (4) @(negedge mclk);
	endtask : frame
endmodule : host_port_model

// ### test_line21_osd_command_and_setup_regs.sv
// self-checking bench for the display command interpreter
`timescale 1ns/1ps
module test_line21_osd_command_and_setup_regs;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic lock_pin = 1'b1;
	logic field_pin = 1'b1;
	logic irq_any = 1'b1;
	logic [7:0] rx_byte, port_status, out_buf_a, out_buf_b;
	logic [7:0] video_setup, display_style, glyph_code;
	logic [3:0] text_row_lines, caption_row_lines, overlay_row_lines;
	logic [3:0] disp_row, phys_row, glyph_row, map_disp;
	logic [5:0] cursor_col, glyph_col;
	logic rx_valid, stat_ack, rd_ack_a, rd_ack_b, frame_pin, map_we;
	logic text_attr_on, caption_attr_on, overlay_attr_on, irq_out_pin;
	logic irq_out_oe, popon_style, charset_ext, disp_tall, glyph_we;
	logic glyph_wide, map_show, map_tall, carriage_return, erase_to_row_end;
	logic swap_memories, erase_shown_memory, erase_hidden_memory;
	logic [4:0] seen = 5'h00;
	logic [18:0] last_glyph;
	logic [5:0] last_map;
	logic [7:0] ops [6] = '{8'h30, 8'h31, 8'h36, 8'h37, 8'h38, 8'h33};
	int fail_count = 0;
	int checks_done = 0;

	line21_osd_command_and_setup_regs u_line21_osd_command_and_setup_regs (.*);
	host_port_model u_host_port_model (.*);

	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		seen <= seen | {carriage_return, erase_to_row_end, swap_memories,
			erase_shown_memory, erase_hidden_memory};
		if (glyph_we)
			last_glyph <= {glyph_row, glyph_wide, glyph_col, glyph_code};
		if (map_we)
			last_map <= {map_disp, map_show, map_tall};
	end

	// ***
	// helpers
	// ***
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	task automatic cmd1(input logic [7:0] a);
		bit late;
		u_host_port_model.send(a, late);
		chk("ready timeout", late, 1'b0);
		if (late)
			end_sim();
	endtask : cmd1
	task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
		cmd1(a);
		cmd1(b);
	endtask : cmd2
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// ***
	// tests
	// ***
	initial begin
		tick(10);
		rst = 1'b0;
		tick(4);
		chk("status", port_status, 8'h8b);
		chk("regs", {video_setup, display_style}, 16'h00c0);
		chk("lines", {text_row_lines, caption_row_lines, overlay_row_lines}, 12'hddf);
		chk("attr", {text_attr_on, caption_attr_on, overlay_attr_on}, 3'b111);
		chk("irq pin", {irq_out_oe, irq_out_pin}, 2'b11);
		$display("reset test done");
		cmd2(8'hc0, 8'hff);
		cmd2(8'hc1, 8'h24);
		tick(2);
		chk("regs", {video_setup, display_style}, 16'h0f24);
		chk("lines", {text_row_lines, caption_row_lines, overlay_row_lines}, 12'hfff);
		chk("attr", {text_attr_on, caption_attr_on, overlay_attr_on}, 3'b001);
		chk("irq pin", {irq_out_oe, irq_out_pin}, 2'b00);
		cmd1(8'h60);
		tick(2);
		chk("read two", {port_status, out_buf_a, out_buf_b}, 24'heb0f24);
		cmd1(8'h41);
		tick(2);
		chk("read one", {port_status, out_buf_a, out_buf_b}, 24'hcf24ff);
		irq_any = 1'b0;
		u_host_port_model.ack(3'b110);
		tick(2);
		chk("status", port_status & 8'hdf, 8'h83);
		$display("register test done");
		cmd1(8'h32);
		tick(2);
		chk("style", popon_style, 1'b0);
		foreach (ops[i])
			cmd1(ops[i]);
		tick(2);
		chk("pulses", {seen, popon_style}, 6'h3f);
		cmd2(8'ha1, 8'h05);
		cmd2(8'ha2, 8'h1f);
		cmd2(8'ha3, 8'h41);
		tick(2);
		chk("glyph", {last_glyph, cursor_col, phys_row}, {4'h5, 15'h1f41, 6'h20, 4'h5});
		cmd2(8'ha8, 8'h00);
		cmd2(8'ha5, 8'hc2);
		tick(2);
		chk("wide", {charset_ext, last_glyph, cursor_col}, {1'b1, 4'h5, 15'h60c2, 6'h20});
		cmd2(8'ha7, 8'h00);
		cmd2(8'ha0, 8'h23);
		cmd2(8'ha4, 8'h35);
		tick(2);
		chk("rows", {charset_ext, disp_row, disp_tall, cursor_col, last_map},
			{1'b0, 4'h3, 1'b1, 6'h01, 6'h17});
		$display("command test done");
		cmd2(8'ha6, 8'h02);
		fork
			cmd2(8'ha1, 8'h07);
			begin
				tick(4);
				chk("held", {phys_row, port_status[7]}, {4'h5, 1'b0});
				u_host_port_model.frame();
				u_host_port_model.frame();
			end
		join
		tick(2);
		chk("released", phys_row, 4'h7);
		cmd2(8'ha6, 8'h02);
		cmd1(8'ha2);
		u_host_port_model.ignore_ready = 1'b1;
		cmd1(8'h11);
		u_host_port_model.ignore_ready = 1'b0;
		tick(2);
		chk("overrun", {port_status[7], port_status[4]}, 2'b01);
		u_host_port_model.ack(3'b100);
		tick(2);
		chk("overrun clear", port_status[4], 1'b0);
		u_host_port_model.frame();
		u_host_port_model.frame();
		cmd1(8'h05);
		tick(2);
		chk("kept", cursor_col, 6'h05);
		cmd1(8'hfb);
		cmd1(8'hfc);
		cmd1(8'h00);
		tick(3);
		chk("defaults", {video_setup, display_style, cursor_col}, {16'h00c0, 6'h00});
		$display("wait and reset test done");
		end_sim();
	end
endmodule : test_line21_osd_command_and_setup_regs
